/* logic/dss_sequencer.sv */
// Function
// - macros 0-3 keep rewriting routing and latch
// - macro 4 leaves routing and latch writable
// - new routing applies only after drive reset
// - fixed routing table for macros 0 to 3
// - latching needs an active run permit input
// - permit loss clears latch and stops drive
// - latch enable is one bit, resets off
// - detection off: frequency starts zero, ramps
// - detection on: test, then load detected frequency
// - run given while stopped skips the test
// - first enable in initial-resistance mode skips test
// - each-start resistance mode always skips test
// - test lasts 250 ms, extendable per motor
// - test drives rated magnetising current
// - setting restricts detected frequency sign
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module dss_sequencer
  import dss_pkg::*;
#(
  parameter int unsigned DETECT_CYC = TEST_CYC_DEF
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire dss_apb_req_s apb_i,
  output dss_apb_rsp_s apb_o,
  input wire logic [2:0] term_i,
  input wire logic drive_enable_i,
  input wire logic [14:0] speed_ref_i,
  input wire logic [15:0] det_freq_i,
  input wire logic det_valid_i,
  output dss_drive_s drive_o
);

  typedef struct packed {
    logic [2:0] macro;
    logic latch_en;
    dss_dest_e [2:0] route;
    dss_dest_e [2:0] act_route;
    logic act_latch;
    logic [1:0] spin;
    dss_vmode_e vmode;
    logic [31:0] ext;
    logic [15:0] ramp;
    logic [15:0] rated;
    logic [7:0] pf;
    dss_state_e state;
    logic [31:0] cnt;
    logic [15:0] det;
    logic held_fwd;
    logic held_rev;
    logic held_run;
    logic en_prev;
    logic first_done;
    dss_apb_rsp_s rsp;
    dss_drive_s drv;
  } dss_state_s;

  function automatic dss_dest_e [2:0] macro_route(input logic [2:0] m);
    dss_dest_e [2:0] r;
    r[0] = m[0] ? DST_PERMIT : DST_NONE;
    r[1] = m[1] ? DST_RUN : DST_FWD;
    r[2] = m[1] ? DST_DIR : DST_REV;
    return r;
  endfunction

  function automatic logic [7:0] isqrt16(input logic [15:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int b = 7; b >= 0; b--) begin
      if (16'((r | (8'h01 << b)) * (r | (8'h01 << b))) <= v) begin
        r = r | (8'h01 << b);
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] ramp_to(input logic [15:0] cur, input logic [15:0] tgt,
                                          input logic [15:0] stp);
    logic signed [17:0] c;
    logic signed [17:0] t;
    logic signed [17:0] s;
    c = 18'(signed'(cur));
    t = 18'(signed'(tgt));
    s = 18'({2'b00, stp});
    if (c + s < t) begin
      return 16'(c + s);
    end else if (c - s > t) begin
      return 16'(c - s);
    end
    return tgt;
  endfunction

  dss_state_s q;
  dss_state_s d;

  logic hit;
  logic wr;
  logic wr_ctrl;
  logic wr_route;
  logic drv_reset;
  logic permit;
  logic has_permit;
  logic permit_ok;
  logic lvl_fwd;
  logic lvl_rev;
  logic lvl_run;
  logic lvl_dir;
  logic run_req;
  logic rev_req;
  logic go;
  logic en_rise;
  logic skip_test;
  logic [31:0] test_len;
  logic [15:0] mag_calc;
  logic [15:0] target;
  logic [15:0] det_kept;
  logic [31:0] rd_data;

  always_comb begin
    d = q;
    hit = 1'b1;
    rd_data = 32'h0000_0000;
    unique case (apb_i.paddr)
      OFS_CTRL: rd_data = {23'h000000, 1'b0, q.vmode, q.spin, q.latch_en, q.macro};
      OFS_ROUTE: rd_data = {23'h000000, q.route};
      OFS_STATUS: rd_data = {q.drv.freq, 1'b0, q.act_route, q.act_latch, q.first_done,
                             q.drv.reverse, q.drv.running, q.state};
      OFS_EXT: rd_data = q.ext;
      OFS_MOTOR: rd_data = {8'h00, q.pf, q.rated};
      OFS_RAMP: rd_data = {16'h0000, q.ramp};
      default: hit = 1'b0;
    endcase
    // one wait state; write lands on the edge that samples pready
    wr = apb_i.psel & apb_i.penable & q.rsp.pready & apb_i.pwrite;
    wr_ctrl = wr & (apb_i.paddr == OFS_CTRL);
    wr_route = wr & (apb_i.paddr == OFS_ROUTE);
    d.rsp.pready = apb_i.psel & apb_i.penable & ~q.rsp.pready;
    d.rsp.pslverr = d.rsp.pready & ~hit;
    d.rsp.prdata = (d.rsp.pready & hit & ~apb_i.pwrite) ? rd_data : 32'h0000_0000;
    drv_reset = wr_ctrl & apb_i.pwdata[RESET_BIT];

    if (wr_ctrl) begin
      if (apb_i.pwdata[MACRO_LSB +: 3] <= MACRO_USER) begin
        d.macro = apb_i.pwdata[MACRO_LSB +: 3];
      end
      if (q.macro == MACRO_USER) begin
        d.latch_en = apb_i.pwdata[LATCH_BIT];
      end
      d.spin = apb_i.pwdata[SPIN_LSB +: 2];
      d.vmode = dss_vmode_e'(apb_i.pwdata[VMODE_LSB +: 2]);
    end
    if (wr_route && q.macro == MACRO_USER) begin
      for (int i = 0; i < 3; i++) begin
        if (apb_i.pwdata[3 * i +: 3] <= 3'(DST_DIR)) begin
          d.route[i] = dss_dest_e'(apb_i.pwdata[3 * i +: 3]);
        end
      end
    end
    if (wr & (apb_i.paddr == OFS_EXT)) begin
      d.ext = apb_i.pwdata;
    end
    if (wr & (apb_i.paddr == OFS_MOTOR)) begin
      d.rated = apb_i.pwdata[RATED_LSB +: 16];
      d.pf = apb_i.pwdata[PF_LSB +: 8];
    end
    if (wr & (apb_i.paddr == OFS_RAMP)) begin
      d.ramp = apb_i.pwdata[15:0];
    end
    if (d.macro != MACRO_USER) begin
      d.route = macro_route(d.macro);
      d.latch_en = d.macro[0];
    end
    if (drv_reset) begin
      d.act_route = d.route;
      d.act_latch = d.latch_en;
    end

    permit = 1'b0;
    has_permit = 1'b0;
    lvl_fwd = 1'b0;
    lvl_rev = 1'b0;
    lvl_run = 1'b0;
    lvl_dir = 1'b0;
    for (int i = 0; i < 3; i++) begin
      unique case (q.act_route[i])
        DST_PERMIT: begin
          permit = permit | term_i[i];
          has_permit = 1'b1;
        end
        DST_FWD: lvl_fwd = lvl_fwd | term_i[i];
        DST_REV: lvl_rev = lvl_rev | term_i[i];
        DST_RUN: lvl_run = lvl_run | term_i[i];
        DST_DIR: lvl_dir = lvl_dir | term_i[i];
        default: ;
      endcase
    end
    // latching without a permit source never runs
    permit_ok = has_permit ? permit : ~q.act_latch;
    d.held_fwd = (lvl_fwd | (q.held_fwd & ~lvl_rev)) & permit_ok & q.act_latch;
    d.held_rev = (lvl_rev | (q.held_rev & ~lvl_fwd)) & permit_ok & q.act_latch;
    d.held_run = (lvl_run | q.held_run) & permit_ok & q.act_latch;
    if (q.act_latch) begin
      // permit gates at once; the held bits only clear a cycle later
      run_req = (q.held_fwd | q.held_rev | q.held_run) & permit_ok;
      rev_req = (q.held_rev & ~q.held_fwd) | (q.held_run & lvl_dir);
    end else begin
      run_req = (lvl_fwd | lvl_rev | lvl_run) & permit_ok;
      rev_req = (lvl_rev & ~lvl_fwd) | (lvl_run & lvl_dir);
    end
    go = run_req & drive_enable_i;

    // reactive share of rated current, pf in 1/256
    mag_calc = 16'((32'(q.rated) * 32'(isqrt16(16'hffff - 16'(q.pf * q.pf)))) >> 8);
    target = rev_req ? 16'(-signed'({1'b0, speed_ref_i})) : {1'b0, speed_ref_i};
    test_len = 32'(DETECT_CYC) + q.ext;
    skip_test = (q.vmode == EACH_START_RESISTANCE_MEASURE_MODE) |
                ((q.vmode == INITIAL_RESISTANCE_MEASURE_MODE) & ~q.first_done);
    en_rise = drive_enable_i & ~q.en_prev;
    d.en_prev = drive_enable_i;
    if (en_rise) begin
      d.first_done = 1'b1;
    end
    // sign restriction of the detected value
    det_kept = q.det;
    if ((q.spin == SPIN_POS && q.det[15]) || (q.spin == SPIN_NEG && !q.det[15])) begin
      det_kept = 16'h0000;
    end

    unique case (q.state)
      ST_STOP: begin
        d.cnt = 32'h0000_0000;
        d.drv.freq = ramp_to(q.drv.freq, 16'h0000, q.ramp);
        if (go && en_rise && q.spin != SPIN_RST && !skip_test) begin
          d.state = ST_DETECT;
          d.det = 16'h0000;
        end else if (go) begin
          d.state = ST_RUN;
          d.drv.freq = 16'h0000;
        end
      end
      ST_DETECT: begin
        d.cnt = q.cnt + 32'h0000_0001;
        if (det_valid_i) begin
          d.det = det_freq_i;
        end
        if (!go) begin
          d.state = ST_STOP;
          d.drv.freq = 16'h0000;
        end else if (q.cnt >= test_len - 32'h0000_0001) begin
          d.state = ST_RUN;
          d.drv.freq = det_kept;
        end
      end
      ST_RUN: begin
        d.drv.freq = ramp_to(q.drv.freq, target, q.ramp);
        if (!go) begin
          // stop on run or permit loss
          d.state = ST_STOP;
        end
      end
      default: d.state = ST_STOP;
    endcase
    if (!drive_enable_i) begin
      d.drv.freq = 16'h0000;
    end
    d.drv.detecting = (d.state == ST_DETECT);
    d.drv.mag_current = d.drv.detecting ? mag_calc : 16'h0000;
    d.drv.running = (d.state != ST_STOP) | (d.drv.freq != 16'h0000);
    d.drv.reverse = d.drv.freq[15];
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.macro <= MACRO_RST;
      q.latch_en <= 1'b0;
      q.route <= '{DST_REV, DST_FWD, DST_NONE};
      q.act_route <= '{DST_REV, DST_FWD, DST_NONE};
      q.spin <= SPIN_RST;
      q.vmode <= INITIAL_RESISTANCE_MEASURE_MODE;
      q.ext <= EXT_RST;
      q.ramp <= RAMP_RST;
      q.rated <= RATED_RST;
      q.pf <= PF_RST;
      q.state <= ST_STOP;
    end else begin
      q <= d;
    end
  end

  assign apb_o = q.rsp;
  assign drive_o = q.drv;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_macro_forced: assert property (q.macro != MACRO_USER |->
    q.route == macro_route(q.macro) && q.latch_en == q.macro[0])
    else $error("routing differs from selected macro");
  a_user_route_kept: assert property (q.macro == MACRO_USER && !wr_ctrl && !wr_route
    |=> $stable(q.route) && $stable(q.latch_en))
    else $error("user routing changed without a write");
  a_active_on_reset: assert property (!drv_reset |=> $stable(q.act_route))
    else $error("active routing changed without drive reset");
  a_permit_stop: assert property (q.state == ST_RUN && q.act_latch && !permit_ok
    |=> q.state == ST_STOP && !q.held_fwd && !q.held_rev)
    else $error("permit loss did not stop the drive");
  a_zero_start: assert property (q.state == ST_STOP ##1 q.state == ST_RUN
    |-> q.drv.freq == 16'h0000)
    else $error("run did not start from zero");
  a_skip_each: assert property (q.vmode == EACH_START_RESISTANCE_MEASURE_MODE
    && q.state == ST_STOP |=> q.state != ST_DETECT)
    else $error("test run in each-start mode");
  a_test_length: assert property (q.state == ST_DETECT && q.cnt == test_len - 32'h1
    && go |=> q.state == ST_RUN)
    else $error("detection test length wrong");
  a_test_bound: assert property (q.state == ST_DETECT |-> q.cnt < test_len)
    else $error("detection test overran");
  a_mag_current: assert property (q.state == ST_DETECT |->
    q.drv.mag_current == $past(mag_calc) && q.drv.detecting)
    else $error("wrong excitation during test");
  a_positive_only: assert property (q.state == ST_DETECT && q.spin == SPIN_POS
    ##1 q.state == ST_RUN |-> !q.drv.freq[15])
    else $error("negative frequency kept in positive-only mode");
  a_macro_range: assert property (q.macro <= MACRO_USER)
    else $error("macro selector out of range");
  a_bus_wait: assert property (apb_i.psel && apb_i.penable && !q.rsp.pready
    |=> q.rsp.pready ##1 !q.rsp.pready)
    else $error("bus answer timing wrong");

  c_detect_run: cover property (q.state == ST_DETECT ##1 q.state == ST_RUN);
  c_latched_run: cover property (q.act_latch && q.held_fwd ##1 !lvl_fwd && q.state == ST_RUN);
  c_permit_drop: cover property (q.state == ST_RUN && q.act_latch ##1 q.state == ST_STOP);
  c_user_macro: cover property (q.macro == MACRO_USER && wr_route);

endmodule // dss_sequencer
`default_nettype wire

/* logic/dss_pkg.sv */
`default_nettype none
package dss_pkg;
  // clock and detection test timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned TEST_TIME_MS = 250;
  localparam int unsigned TEST_CYC_DEF = TEST_TIME_MS * (CLK_HZ / 1000);

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ROUTE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_EXT = 8'h0c;
  localparam logic [7:0] OFS_MOTOR = 8'h10;
  localparam logic [7:0] OFS_RAMP = 8'h14;

  // control and motor register field positions
  localparam int unsigned MACRO_LSB = 0;
  localparam int unsigned LATCH_BIT = 3;
  localparam int unsigned SPIN_LSB = 4;
  localparam int unsigned VMODE_LSB = 6;
  localparam int unsigned RESET_BIT = 8;
  localparam int unsigned RATED_LSB = 0;
  localparam int unsigned PF_LSB = 16;

  // reset values and limits
  localparam logic [2:0] MACRO_RST = 3'h0;
  localparam logic [2:0] MACRO_USER = 3'h4;
  localparam logic [1:0] SPIN_RST = 2'h0;
  localparam logic [1:0] SPIN_ALL = 2'h1;
  localparam logic [1:0] SPIN_POS = 2'h2;
  localparam logic [1:0] SPIN_NEG = 2'h3;
  localparam logic [15:0] RAMP_RST = 16'h0001;
  localparam logic [15:0] RATED_RST = 16'h0000;
  localparam logic [7:0] PF_RST = 8'hd9;
  localparam logic [31:0] EXT_RST = 32'h0000_0000;

  typedef enum logic [2:0] {
    DST_NONE, DST_PERMIT, DST_FWD, DST_REV, DST_RUN, DST_DIR
  } dss_dest_e;

  typedef enum logic [1:0] {
    INITIAL_RESISTANCE_MEASURE_MODE,
    EACH_START_RESISTANCE_MEASURE_MODE,
    FIXED_BOOST_MODE,
    SQUARE_LAW_MODE
  } dss_vmode_e;

  typedef enum logic [1:0] {ST_STOP, ST_DETECT, ST_RUN} dss_state_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } dss_apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dss_apb_rsp_s;

  typedef struct packed {
    logic [15:0] freq;
    logic [15:0] mag_current;
    logic running;
    logic reverse;
    logic detecting;
  } dss_drive_s;
endpackage
`default_nettype wire

/* tb/dss_motor_model.sv */
`timescale 1ns/100ps
`default_nettype none
module dss_motor_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic detecting_i,
  input wire logic slow_i,
  input wire logic [15:0] spin_i,
  output logic [15:0] det_freq_o,
  output logic det_valid_o
);
  logic [3:0] cnt_q;
  logic hit;
  assign hit = detecting_i && (cnt_q == (slow_i ? 4'hc : 4'h1));
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 4'h0;
      det_valid_o <= 1'b0;
      det_freq_o <= 16'h0000;
    end else begin
      cnt_q <= detecting_i ? cnt_q + 4'h1 : 4'h0;
      det_valid_o <= hit;
      // churn when not valid so a stale value looks right only every other cycle
      det_freq_o <= hit ? spin_i : ~det_freq_o;
    end
  end
endmodule // dss_motor_model
`default_nettype wire

/* tb/dss_sequencer_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module dss_sequencer_tb;
  import dss_pkg::*;
  localparam int DC = 20;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  dss_apb_req_s req = '0;
  dss_apb_rsp_s rsp;
  logic [2:0] term = 3'h0;
  logic en = 1'b0;
  logic [14:0] sref = 15'h0000;
  dss_drive_s drv;
  logic [15:0] dfreq, spin = 16'h0000, mexp;
  logic dval, slow = 1'b0, err;
  logic [31:0] rd, rr;
  int mismatches = 0, tests_run = 0;
  logic [1:0] sps[6] = '{2'h1, 2'h1, 2'h2, 2'h3, 2'h1, 2'h1};
  logic [1:0] vms[6] = '{2'h0, 2'h0, 2'h2, 2'h3, 2'h1, 2'h2};
  logic lts[6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  logic exs[6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

  always #10 clk_i = ~clk_i;

  dss_sequencer #(.DETECT_CYC(DC)) dss_sequencer_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .apb_i(req), .apb_o(rsp), .term_i(term), .drive_enable_i(en), .speed_ref_i(sref),
    .det_freq_i(dfreq), .det_valid_i(dval), .drive_o(drv));
  dss_motor_model dss_motor_model_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .detecting_i(drv.detecting), .slow_i(slow), .spin_i(spin), .det_freq_o(dfreq),
    .det_valid_o(dval));

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // hold request until pready is seen at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_i);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) chk("pready", 1, 0);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask

  task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask

  function automatic int isq(int v);
    int r = 0;
    while ((r + 1) * (r + 1) <= v) r++;
    return r;
  endfunction

  function automatic logic [31:0] route(int m);
    return (m[0] ? 1 : 0) | ((m < 2 ? 2 : 4) << 3) | ((m < 2 ? 3 : 5) << 6);
  endfunction

  function automatic logic [15:0] fexp(logic [1:0] s, logic [15:0] f);
    if ((s == SPIN_POS && f[15]) || (s == SPIN_NEG && !f[15])) return 16'h0000;
    return f;
  endfunction

  task start(input int i);
    int n, ext;
    logic [15:0] mg, fq;
    n = 0;
    ext = $urandom_range(0, 7);
    en <= 1'b0;
    term <= 3'h0;
    // negative spin in the positive-only case, so the sign filter is exercised
    spin <= {i[1], 15'($urandom)};
    slow <= 1'($urandom);
    apb(1'b1, OFS_EXT, ext);
    apb(1'b1, OFS_CTRL, {23'h0, 1'b1, vms[i], sps[i], 4'h0});
    if (lts[i]) en <= 1'b1;
    else term <= 3'b010;
    repeat (2) @(posedge clk_i);
    if (lts[i]) term <= 3'b010;
    else en <= 1'b1;
    repeat (DC + 20) begin
      @(posedge clk_i);
      if (drv.detecting === 1'b1) begin
        n++;
        mg = drv.mag_current;
      end else if (n > 0 && n == DC + ext) fq = drv.freq;
    end
    chk("detect cycles", exs[i] ? DC + ext : 0, n);
    if (exs[i]) chk("magnetising", mexp, mg);
    if (exs[i]) chk("start freq", fexp(sps[i], spin), fq);
    if (!exs[i]) chk("zero start", 16'h0000, drv.freq);
    $display("test start %0d done", i);
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    #200us;
    mismatches++;
    wrap_up;
  end

  initial begin
    logic [15:0] f1;
    void'($urandom(32'h0e511954));
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rdc("ctrl rst", OFS_CTRL, 0);
    rdc("route rst", OFS_ROUTE, route(0));
    rdc("status rst", OFS_STATUS, route(0) << 6);
    rdc("motor rst", OFS_MOTOR, {8'h0, PF_RST, RATED_RST});
    rdc("ramp rst", OFS_RAMP, 32'(RAMP_RST));
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped err", 1, err);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, OFS_CTRL, 32'(m) | 32'h8);
      apb(1'b1, OFS_ROUTE, $urandom);
      rdc("macro ctrl", OFS_CTRL, 32'(m) | (m[0] << 3));
      rdc("macro route", OFS_ROUTE, route(m));
    end
    rr = {23'h0, 3'($urandom_range(0, 5)), 3'($urandom_range(0, 5)), 3'($urandom_range(0, 5))};
    apb(1'b1, OFS_CTRL, 32'h4);
    apb(1'b1, OFS_ROUTE, rr);
    rdc("user route", OFS_ROUTE, rr);
    apb(1'b1, OFS_CTRL, 32'hc);
    rdc("user latch", OFS_CTRL, 32'hc);
    apb(1'b1, OFS_CTRL, 32'h5);
    rdc("macro limit", OFS_CTRL, 32'h4);
    rdc("active held", OFS_STATUS, route(0) << 6);
    apb(1'b1, OFS_CTRL, 32'h104);
    rdc("active new", OFS_STATUS, rr << 6);
    apb(1'b1, OFS_CTRL, 32'h100);
    $display("test registers done");
    rr = $urandom;
    apb(1'b1, OFS_MOTOR, rr & 32'h00ff_ffff);
    mexp = 16'((rr[15:0] * isq(65535 - rr[23:16] * rr[23:16])) >> 8);
    apb(1'b1, OFS_RAMP, 32'h0);
    for (int i = 0; i < 6; i++) start(i);
    en <= 1'b0;
    term <= 3'h0;
    sref <= 15'd30;
    apb(1'b1, OFS_RAMP, 32'h3);
    apb(1'b1, OFS_CTRL, 32'h180);
    en <= 1'b1;
    term <= 3'b010;
    f1 = 16'h0;
    repeat (30) begin
      @(posedge clk_i);
      if (f1 == 16'h0) f1 = drv.freq;
    end
    chk("ramp first", 16'd3, f1);
    chk("ramp final", 16'd30, drv.freq);
    chk("running", 1'b1, drv.running);
    term <= 3'b100;
    repeat (25) @(posedge clk_i);
    chk("ramp reverse", 16'hffe2, drv.freq);
    chk("reverse flag", 1'b1, drv.reverse);
    $display("test ramp done");
    en <= 1'b0;
    term <= 3'h0;
    apb(1'b1, OFS_CTRL, 32'h101);
    en <= 1'b1;
    term <= 3'b010;
    repeat (4) @(posedge clk_i);
    term <= 3'b000;
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("no permit", 0, rd[1:0]);
    term <= 3'b011;
    @(posedge clk_i);
    term <= 3'b001;
    repeat (6) @(posedge clk_i);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("latched run", 32'h26, rd[5:0] & 32'h27);
    term <= 3'b000;
    repeat (4) @(posedge clk_i);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("permit drop", 0, rd[1:0]);
    $display("test latch done");
    wrap_up;
  end
endmodule // dss_sequencer_tb
`default_nettype wire
